// file: rtl/cah_host_regs.sv
// host register bank of the channel adapter: interrupt, status, error,
// data, switch and mask registers, test modes, channel dma reads.
// assumes an apb master on pclk and a switch input already synchronous.
`timescale 1ns/100ps
module cah_host_regs #(
	parameter int PAGE_W = cah_pkg::CAH_PAGE_W,
	parameter int OFFS_W = cah_pkg::CAH_OFFS_W,
	parameter logic [4:0] JUMP_ADDR = cah_pkg::CAH_JUMP_ADDR_DEF
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [cah_pkg::CAH_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// front panel
	input wire logic sw_enable,
	// channel dma read
	input wire logic chan_rd_req,
	input wire logic [PAGE_W-1:0] chan_rd_page,
	input wire logic [OFFS_W-1:0] chan_rd_offset,
	output logic [cah_pkg::CAH_REG_W-1:0] chan_rd_data,
	output logic chan_rd_valid,
	// host interrupt level 3
	output logic irq_level3
);
	import cah_pkg::*;

	localparam int AW = PAGE_W + OFFS_W;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic [CAH_CTRL_MODE_W-1:0] mode;
		logic go;
		cah_seq_t seq;
		logic [15:0] irq;
		logic [15:0] status;
		logic [15:0] error;
		logic [15:0] data;
		logic [15:0] mask;
		logic sw_prev;
		logic sw_seen;
		logic [AW-1:0] mem_addr;
		logic chan_pend;
		logic [15:0] chan_data;
		logic chan_valid;
		logic irq_out;
	} cah_st_t;

	localparam cah_st_t ST_RST = '{
		prdata: '0,
		pready: 1'b0,
		pslverr: 1'b0,
		mode: CAH_MODE_OPER,
		go: 1'b0,
		seq: CAH_SEQ_IDLE,
		irq: '0,
		status: '0,
		error: '0,
		data: '0,
		mask: CAH_MASK_RST,
		sw_prev: 1'b0,
		sw_seen: 1'b0,
		mem_addr: '0,
		chan_pend: 1'b0,
		chan_data: '0,
		chan_valid: 1'b0,
		irq_out: 1'b0
	};

	cah_st_t r;
	cah_st_t n;

	logic setup;
	logic wr_acc;
	logic rd_acc;
	logic [15:0] rd_clr;
	logic [15:0] irq_set;
	logic [15:0] stat_set;
	logic [15:0] err_set;
	logic [15:0] rd_word;
	logic mapped;
	logic err_ld;
	logic force_hold;

	cah_mem_if #(.AW(AW), .DW(CAH_REG_W)) mem ();

	cah_local_ram #(
		.PAGE_W(PAGE_W),
		.OFFS_W(OFFS_W),
		.DW(CAH_REG_W)
	) u_ram (
		.pclk(pclk),
		.presetn(presetn),
		.mem(mem)
	);

	// apb phases; an access completes at the edge where pready is seen
	assign setup = psel & ~penable;
	assign wr_acc = psel & penable & r.pready & pwrite;
	assign rd_acc = psel & penable & r.pready & ~pwrite;
	// only the bits actually returned are cleared, so a later set survives
	assign rd_clr = rd_acc ? r.prdata[15:0] : 16'h0000;

	// ram hookup: processor fills, channel fetches
	assign mem.wr_en = wr_acc && (paddr == CAH_OFF_MEM_DATA);
	assign mem.wr_addr = r.mem_addr;
	assign mem.wr_data = pwdata[15:0];
	assign mem.rd_req = chan_rd_req;
	assign mem.rd_addr = {chan_rd_page, chan_rd_offset};

	// read decode; the word is caught in setup and held as prdata
	// unmapped and unaligned addresses fall to default and are refused
	always_comb begin
		rd_word = 16'h0000;
		mapped = 1'b1;
		case (paddr)
			CAH_OFF_CTRL: begin
				rd_word[CAH_CTRL_MODE_LSB +: CAH_CTRL_MODE_W] = r.mode;
				rd_word[CAH_CTRL_GO_BIT] = r.go;
				rd_word[CAH_CTRL_SEQ_LSB +: 3] = r.seq;
			end
			CAH_OFF_IRQ: rd_word = r.irq;
			CAH_OFF_STATUS: rd_word = r.status;
			CAH_OFF_ERROR: rd_word = r.error;
			CAH_OFF_DATA: rd_word = r.data;
			CAH_OFF_SWITCH: rd_word[0] = r.sw_prev;
			CAH_OFF_MASK: rd_word = r.mask;
			CAH_OFF_MEM_ADDR: rd_word[AW-1:0] = r.mem_addr;
			CAH_OFF_MEM_DATA: rd_word = 16'h0000;
			default: mapped = 1'b0;
		endcase
	end

	// next state
	always_comb begin
		irq_set = 16'h0000;
		stat_set = 16'h0000;
		err_set = 16'h0000;
		err_ld = 1'b0;
		force_hold = 1'b0;
		n = r;

		// answer prepared in setup, shown during the access phase
		n.pready = setup;
		n.pslverr = setup & ~mapped;
		if (setup) begin
			n.prdata = {16'h0000, rd_word};
		end

		// test-mode sequencer; apply lasts one cycle so each go write
		// sets the forced bits once, and hold waits for go written low
		case (r.seq)
			CAH_SEQ_IDLE: begin
			end
			CAH_SEQ_APPLY: begin
				n.seq = CAH_SEQ_HOLD;
				case (r.mode)
					CAH_MODE_OPER: begin
						stat_set[CAH_STAT_OPER_BIT] = 1'b1;
					end
					CAH_MODE_JUMP: begin
						err_ld = 1'b1;
					end
					CAH_MODE_FORCE: begin
						irq_set = CAH_IRQ_ALL;
						stat_set = CAH_STAT_ALL;
						err_set = CAH_ERR_ALL;
					end
					default: begin
					end
				endcase
			end
			CAH_SEQ_HOLD: begin
				if (!r.go) begin
					n.seq = CAH_SEQ_IDLE;
				end
			end
			default: n.seq = CAH_SEQ_IDLE;
		endcase

		// control write starts or ends a test mode
		if (wr_acc && (paddr == CAH_OFF_CTRL)) begin
			n.mode = pwdata[CAH_CTRL_MODE_LSB +: CAH_CTRL_MODE_W];
			n.go = pwdata[CAH_CTRL_GO_BIT];
			if (pwdata[CAH_CTRL_GO_BIT]) begin
				n.seq = CAH_SEQ_APPLY;
			end
		end

		// switch: first sample after reset is not an event
		// sw_seen keeps the level present at release from looking like
		// a throw of the switch
		n.sw_prev = sw_enable;
		n.sw_seen = 1'b1;
		if (r.sw_seen && (sw_enable != r.sw_prev)) begin
			irq_set[CAH_IRQ_SWITCH_BIT] = 1'b1;
		end

		// channel dma read completion and overrun
		// the ram answers each request on the next edge, so a back-to-back
		// request meets rd_valid and is not taken as an overrun
		n.chan_valid = 1'b0;
		if (mem.rd_valid) begin
			n.chan_pend = 1'b0;
			n.chan_data = mem.rd_data;
			n.chan_valid = 1'b1;
			stat_set[CAH_STAT_DMA_BIT] = 1'b1;
			irq_set[CAH_IRQ_DMA_BIT] = 1'b1;
		end
		if (chan_rd_req) begin
			if (r.chan_pend && !mem.rd_valid) begin
				err_set[CAH_ERR_OVR_BIT] = 1'b1;
			end
			n.chan_pend = 1'b1;
		end

		// interrupt register, clear on read, set wins
		// a bit set in the cycle of its clearing read is kept
		if (paddr == CAH_OFF_IRQ) begin
			n.irq = (r.irq & ~rd_clr) | irq_set;
		end else begin
			n.irq = r.irq | irq_set;
		end

		// status register, writable for wrap, clear on read
		if (wr_acc && (paddr == CAH_OFF_STATUS)) begin
			n.status = pwdata[15:0] | stat_set;
		end else if (paddr == CAH_OFF_STATUS) begin
			n.status = (r.status & ~rd_clr) | stat_set;
		end else begin
			n.status = r.status | stat_set;
		end

		// error register, clear on read, jump address load
		if (paddr == CAH_OFF_ERROR) begin
			n.error = r.error & ~rd_clr;
		end
		if (err_ld) begin
			n.error[CAH_ERR_ADDR_LSB +: CAH_ERR_ADDR_W] = JUMP_ADDR;
		end
		n.error = n.error | err_set;

		// read/write registers; mask keeps only the cause bits, memory address steps on each ram write
		if (wr_acc && (paddr == CAH_OFF_DATA)) begin
			n.data = pwdata[15:0];
		end
		if (wr_acc && (paddr == CAH_OFF_MASK)) begin
			n.mask = pwdata[15:0] & CAH_IRQ_ALL;
		end
		if (wr_acc && (paddr == CAH_OFF_MEM_ADDR)) begin
			n.mem_addr = pwdata[AW-1:0];
		end else if (mem.wr_en) begin
			n.mem_addr = r.mem_addr + 1'b1;
		end

		// level-3 request: unmasked pending bits or forced test mode
		// force ignores the mask, so the forced request shows even
		// when software has masked every cause
		force_hold = (n.seq != CAH_SEQ_IDLE) && (n.mode == CAH_MODE_FORCE);
		n.irq_out = (|(n.irq & n.mask)) | force_hold;
	end

	// state register
	// reset loads a constant, so the async branch holds no logic
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= ST_RST;
		end else begin
			r <= n;
		end
	end

	// outputs straight from state
	assign prdata = r.prdata;
	assign pready = r.pready;
	assign pslverr = r.pslverr;
	assign chan_rd_data = r.chan_data;
	assign chan_rd_valid = r.chan_valid;
	assign irq_level3 = r.irq_out;

endmodule : cah_host_regs

// file: rtl/cah_pkg.sv
// register map, field layout and reset values of the channel adapter
// host registers; shared by the register bank and its local ram.
package cah_pkg;

	// apb address width seen by the block
	localparam int CAH_AW = 8;
	localparam int CAH_REG_W = 16;

	// register byte offsets
	localparam logic [7:0] CAH_OFF_CTRL = 8'h00;
	localparam logic [7:0] CAH_OFF_IRQ = 8'h04;
	localparam logic [7:0] CAH_OFF_STATUS = 8'h08;
	localparam logic [7:0] CAH_OFF_ERROR = 8'h0C;
	localparam logic [7:0] CAH_OFF_DATA = 8'h10;
	localparam logic [7:0] CAH_OFF_SWITCH = 8'h14;
	localparam logic [7:0] CAH_OFF_MASK = 8'h18;
	localparam logic [7:0] CAH_OFF_MEM_ADDR = 8'h1C;
	localparam logic [7:0] CAH_OFF_MEM_DATA = 8'h20;

	// control register fields
	localparam int CAH_CTRL_MODE_LSB = 0;
	localparam int CAH_CTRL_MODE_W = 2;
	localparam int CAH_CTRL_GO_BIT = 2;
	localparam int CAH_CTRL_SEQ_LSB = 3;

	// test modes
	localparam logic [1:0] CAH_MODE_OPER = 2'h0;
	localparam logic [1:0] CAH_MODE_JUMP = 2'h1;
	localparam logic [1:0] CAH_MODE_FORCE = 2'h2;

	// adapter interrupt register bits
	localparam int CAH_IRQ_SWITCH_BIT = 0;
	localparam int CAH_IRQ_SEQ_BIT = 1;
	localparam int CAH_IRQ_DMA_BIT = 2;
	localparam logic [15:0] CAH_IRQ_ALL = 16'h0007;

	// status register bits
	localparam int CAH_STAT_OPER_BIT = 0;
	localparam int CAH_STAT_DMA_BIT = 1;
	localparam logic [15:0] CAH_STAT_ALL = 16'h0003;

	// error register fields
	localparam int CAH_ERR_OVR_BIT = 0;
	localparam int CAH_ERR_ADDR_LSB = 11;
	localparam int CAH_ERR_ADDR_W = 5;
	localparam logic [15:0] CAH_ERR_ALL = 16'hF801;

	// reset values and default jump address
	localparam logic [15:0] CAH_MASK_RST = 16'h0007;
	localparam logic [4:0] CAH_JUMP_ADDR_DEF = 5'h15;

	// local ram geometry
	localparam int CAH_PAGE_W = 3;
	localparam int CAH_OFFS_W = 4;

	// test-mode sequencer states
	typedef enum logic [2:0] {
		CAH_SEQ_IDLE = 3'b001,
		CAH_SEQ_APPLY = 3'b010,
		CAH_SEQ_HOLD = 3'b100
	} cah_seq_t;

endpackage : cah_pkg

// file: rtl/cah_mem_if.sv
// bundle between the register bank and its local ram.
// assumes one clock shared by both ends.
`timescale 1ns/100ps
interface cah_mem_if #(
	parameter int AW = 7,
	parameter int DW = 16
);
	logic wr_en;
	logic [AW-1:0] wr_addr;
	logic [DW-1:0] wr_data;
	logic rd_req;
	logic [AW-1:0] rd_addr;
	logic [DW-1:0] rd_data;
	logic rd_valid;

	// register bank side
	modport ctl (
		output wr_en, wr_addr, wr_data, rd_req, rd_addr,
		input rd_data, rd_valid
	);

	// ram side
	modport ram (
		input wr_en, wr_addr, wr_data, rd_req, rd_addr,
		output rd_data, rd_valid
	);
endinterface : cah_mem_if

// file: rtl/cah_local_ram.sv
// paged local ram read by channel dma and written by the processor.
// assumes single clock; read answers one cycle after the request.
`timescale 1ns/100ps
module cah_local_ram #(
	parameter int PAGE_W = cah_pkg::CAH_PAGE_W,
	parameter int OFFS_W = cah_pkg::CAH_OFFS_W,
	parameter int DW = cah_pkg::CAH_REG_W
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// ram port
	cah_mem_if.ram mem
);
	import cah_pkg::*;

	localparam int AW = PAGE_W + OFFS_W;
	localparam int DEPTH = 1 << AW;

	typedef struct packed {
		logic [DW-1:0] rd_data;
		logic rd_valid;
	} cah_ram_st_t;

	cah_ram_st_t r;
	cah_ram_st_t n;
	logic [DW-1:0] store [DEPTH];

	// every page, including the upper ones, reads alike
	always_comb begin
		n = r;
		n.rd_valid = mem.rd_req;
		if (mem.rd_req) begin
			n.rd_data = store[mem.rd_addr];
		end
	end

	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	// ram array holds no reset
	always_ff @(posedge pclk) begin
		if (mem.wr_en) begin
			store[mem.wr_addr] <= mem.wr_data;
		end
	end

	assign mem.rd_data = r.rd_data;
	assign mem.rd_valid = r.rd_valid;

endmodule : cah_local_ram

// file: test/cah_regs_sva.sv
// checker on the host register bank ports.
// assumes one clock and an active-low async reset.
`timescale 1ns/100ps
module cah_regs_sva #(
	parameter int PAGE_W = 3,
	parameter int OFFS_W = 4
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [cah_pkg::CAH_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// switch, dma, interrupt
	input wire logic sw_enable,
	input wire logic chan_rd_req,
	input wire logic [PAGE_W-1:0] chan_rd_page,
	input wire logic [OFFS_W-1:0] chan_rd_offset,
	input wire logic [cah_pkg::CAH_REG_W-1:0] chan_rd_data,
	input wire logic chan_rd_valid,
	input wire logic irq_level3
);
	import cah_pkg::*;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// apb answer timing and shape
	a_ready_after_setup: assert property (psel && !penable |=> pready)
		else $error("no answer after setup");
	a_ready_one_cycle: assert property (pready |=> !pready)
		else $error("answer held too long");
	a_err_unaligned: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
		else $error("unaligned not refused");
	a_rdata_upper_zero: assert property (pready |-> prdata[31:16] == 16'h0)
		else $error("upper read bits set");
	// interrupt causes
	a_force_irq: assert property (pready && pwrite && paddr == CAH_OFF_CTRL
		&& pwdata[2:0] == 3'h6 |-> ##[2:3] irq_level3 [*4])
		else $error("force mode irq missing");
	a_switch_irq: assert property ($changed(sw_enable) |-> ##[1:2] irq_level3)
		else $error("switch irq missing");
	// channel dma answer
	a_dma_latency: assert property (chan_rd_req |-> ##2 chan_rd_valid)
		else $error("dma answer late");
	a_dma_cause: assert property (chan_rd_valid |-> $past(chan_rd_req, 2))
		else $error("dma answer uncaused");
	a_dma_data_hold: assert property (chan_rd_valid ##1 !chan_rd_valid
		|-> $stable(chan_rd_data))
		else $error("dma data not held");
	// main scenarios reached
	c_dma: cover property (chan_rd_valid);
	c_switch: cover property ($changed(sw_enable));
	c_irq_drop: cover property (irq_level3 ##1 !irq_level3);
endmodule : cah_regs_sva
bind cah_host_regs cah_regs_sva #(
	.PAGE_W(PAGE_W),
	.OFFS_W(OFFS_W)
) u_sva (
	.pclk(pclk),
	.presetn(presetn),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.paddr(paddr),
	.pwdata(pwdata),
	.prdata(prdata),
	.pready(pready),
	.pslverr(pslverr),
	.sw_enable(sw_enable),
	.chan_rd_req(chan_rd_req),
	.chan_rd_page(chan_rd_page),
	.chan_rd_offset(chan_rd_offset),
	.chan_rd_data(chan_rd_data),
	.chan_rd_valid(chan_rd_valid),
	.irq_level3(irq_level3)
);

// file: test/cah_apb_host.sv
// apb master standing in for the local system processor.
// assumes the bank answers with pready; the bench cuts hangs.
`timescale 1ns/100ps
module cah_apb_host (
	// clock
	input wire logic pclk,
	// request
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [cah_pkg::CAH_AW-1:0] paddr,
	output logic [31:0] pwdata,
	// answer
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	// idle bus at time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
	end
	// setup, access until pready, then release
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a; // released address and data lines never keep the old value
		pwdata <= ~wd;
	endtask : xfer
endmodule : cah_apb_host

// file: test/tb_channel_adapter_host_regs.sv
// self-checking bench for the channel adapter host register bank.
// assumes the apb host model and the bound checker.
`timescale 1ns/100ps
module tb_channel_adapter_host_regs;
	import cah_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [CAH_AW-1:0] paddr;
	logic [31:0] pwdata, prdata;
	logic sw_enable, chan_rd_req, chan_rd_valid, irq_level3;
	logic [2:0] chan_rd_page;
	logic [3:0] chan_rd_offset;
	logic [15:0] chan_rd_data;
	int num_errors = 0;
	int checks = 0;
	int cycles = 0;
	cah_host_regs DUT (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.sw_enable(sw_enable),
		.chan_rd_req(chan_rd_req),
		.chan_rd_page(chan_rd_page),
		.chan_rd_offset(chan_rd_offset),
		.chan_rd_data(chan_rd_data),
		.chan_rd_valid(chan_rd_valid),
		.irq_level3(irq_level3)
	);
	cah_apb_host host (
		.pclk(pclk),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr)
	);
	// clock
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	// hang guard
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 3000) begin
			num_errors++;
			complete_run;
		end
	end
	task cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask : cyc
	task chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		host.xfer(1'b1, a, d, r, e);
	endtask : wr
	task rd(input logic [7:0] a, input logic [31:0] x);
		logic [31:0] r;
		logic e;
		host.xfer(1'b0, a, 32'h0, r, e);
		chk(r, x);
	endtask : rd
	task irq_is(input logic x);
		chk({31'h0, irq_level3}, {31'h0, x});
	endtask : irq_is
	task mode(input logic [1:0] m);
		wr(CAH_OFF_CTRL, 32'h0);
		wr(CAH_OFF_CTRL, {29'h0, 1'b1, m});
		cyc(4);
	endtask : mode
	task dma(input int p);
		wr(CAH_OFF_MEM_ADDR, 32'(p * 16 + 3));
		wr(CAH_OFF_MEM_DATA, 32'(p * 4369));
		chan_rd_page <= 3'(p);
		chan_rd_offset <= 4'h3;
		chan_rd_req <= 1'b1;
		@(posedge pclk);
		chan_rd_req <= 1'b0;
		@(posedge pclk);
		@(negedge pclk);
		chk({15'h0, chan_rd_valid, chan_rd_data}, 32'(65536 + p * 4369));
		@(negedge pclk);
		chk({15'h0, chan_rd_valid, chan_rd_data}, 32'(p * 4369));
	endtask : dma
	task test_map;
		logic [31:0] r;
		logic e;
		rd(CAH_OFF_MASK, 32'h7);
		wr(CAH_OFF_IRQ, 32'hFFFF);
		rd(CAH_OFF_IRQ, 32'h0);
		host.xfer(1'b0, 8'h24, 32'h0, r, e);
		chk({r[30:0], e}, 32'h1);
		host.xfer(1'b1, 8'h11, 32'hFFFF, r, e);
		chk({r[30:0], e}, 32'h1);
		rd(CAH_OFF_DATA, 32'h0);
		$display("test_map done");
	endtask : test_map
	task test_wrap;
		wr(CAH_OFF_STATUS, 32'hFFFFA5C3);
		wr(CAH_OFF_DATA, 32'h5A3C);
		rd(CAH_OFF_STATUS, 32'hA5C3);
		rd(CAH_OFF_STATUS, 32'h0);
		rd(CAH_OFF_DATA, 32'h5A3C);
		rd(CAH_OFF_DATA, 32'h5A3C);
		$display("test_wrap done");
	endtask : test_wrap
	task test_switch;
		rd(CAH_OFF_SWITCH, 32'h0);
		sw_enable <= 1'b1;
		cyc(3);
		irq_is(1'b1);
		rd(CAH_OFF_SWITCH, 32'h1);
		rd(CAH_OFF_IRQ, 32'h1);
		cyc(2);
		irq_is(1'b0);
		rd(CAH_OFF_IRQ, 32'h0);
		sw_enable <= 1'b0;
		cyc(3);
		rd(CAH_OFF_IRQ, 32'h1);
		$display("test_switch done");
	endtask : test_switch
	task test_modes;
		mode(CAH_MODE_OPER);
		rd(CAH_OFF_STATUS, 32'h1);
		rd(CAH_OFF_STATUS, 32'h0);
		mode(CAH_MODE_JUMP);
		rd(CAH_OFF_ERROR, {16'h0, CAH_JUMP_ADDR_DEF, 11'h0});
		rd(CAH_OFF_ERROR, 32'h0);
		mode(CAH_MODE_FORCE);
		irq_is(1'b1);
		rd(CAH_OFF_IRQ, {16'h0, CAH_IRQ_ALL});
		rd(CAH_OFF_STATUS, {16'h0, CAH_STAT_ALL});
		rd(CAH_OFF_ERROR, {16'h0, CAH_ERR_ALL});
		rd(CAH_OFF_IRQ, 32'h0);
		rd(CAH_OFF_ERROR, 32'h0);
		rd(CAH_OFF_CTRL, {26'h0, CAH_SEQ_HOLD, 1'b1, CAH_MODE_FORCE});
		irq_is(1'b1);
		wr(CAH_OFF_CTRL, 32'h0);
		cyc(3);
		irq_is(1'b0);
		$display("test_modes done");
	endtask : test_modes
	task test_dma;
		wr(CAH_OFF_MASK, 32'h3);
		for (int p = 5; p < 8; p++) begin
			dma(p);
		end
		irq_is(1'b0);
		rd(CAH_OFF_IRQ, 32'h4);
		rd(CAH_OFF_STATUS, 32'h2);
		rd(CAH_OFF_MEM_ADDR, 32'h74);
		wr(CAH_OFF_MASK, 32'h7);
		dma(7);
		irq_is(1'b1);
		$display("test_dma done");
	endtask : test_dma
	task test_reset;
		wr(CAH_OFF_MASK, 32'h6);
		presetn <= 1'b0;
		@(negedge pclk);
		irq_is(1'b0);
		chk({15'h0, chan_rd_valid, chan_rd_data}, 32'h0);
		cyc(3);
		presetn <= 1'b1;
		rd(CAH_OFF_MASK, {16'h0, CAH_MASK_RST});
		rd(CAH_OFF_IRQ, 32'h0);
		rd(CAH_OFF_STATUS, 32'h0);
		$display("test_reset done");
	endtask : test_reset
	task complete_run;
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : complete_run
	// reset, then the scenarios
	initial begin
		presetn = 1'b0;
		sw_enable = 1'b0;
		chan_rd_req = 1'b0;
		chan_rd_page = 3'h0;
		chan_rd_offset = 4'h0;
		cyc(3);
		presetn <= 1'b1;
		test_map;
		test_wrap;
		test_switch;
		test_modes;
		test_dma;
		test_reset;
		complete_run;
	end
endmodule : tb_channel_adapter_host_regs
